// >>> mtap_consts.vh
// Purpose: constants of the mapped translation-buffer access port
// Assumes: longword accesses only, 32-bit address and data
// Notes:   ranges are used as vec[`NAME]
`ifndef MTAP_CONSTS_VH
`define MTAP_CONSTS_VH

// ************************************************************
// array codes and address fields
// ************************************************************
`define MTAP_CODE8_RNG      31:24
`define MTAP_CODE9_RNG      31:23
`define MTAP_INSTRUCTION_TRANSLATION_BUFFER_AA_CODE   8'hF2
`define MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA1_CODE  9'h1E6
`define MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA2_CODE  9'h1E7
`define MTAP_UNIFIED_TRANSLATION_BUFFER_AA_CODE   8'hF6
`define MTAP_UNIFIED_TRANSLATION_BUFFER_DA1_CODE  9'h1EE
`define MTAP_INSTRUCTION_TRANSLATION_BUFFER_IDX_RNG   9:8
`define MTAP_UNIFIED_TRANSLATION_BUFFER_IDX_RNG   13:8
`define MTAP_ASSOC_BIT      7
`define MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES   4
`define MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES   64

// ************************************************************
// data field positions
// ************************************************************
`define MTAP_VPN_RNG        31:10
`define MTAP_DIRTY_AA_BIT   9
`define MTAP_VALID_BIT      8
`define MTAP_ADDRESS_SPACE_TAG_RNG       7:0
`define MTAP_PPN_RNG        28:10
`define MTAP_SZ_HI_BIT      7
`define MTAP_SZ_LO_BIT      4
`define MTAP_PR_HI_BIT      6
`define MTAP_PR_LO_BIT      5
`define MTAP_CACHE_BIT      3
`define MTAP_DIRTY_DA_BIT   2
`define MTAP_SHARED_BIT     1
`define MTAP_WT_BIT         0
`define MTAP_SA_RNG         2:0
`define MTAP_TC_BIT         3

// ************************************************************
// page size compare masks over the page number field
// ************************************************************
`define MTAP_SZ_1K          2'h0
`define MTAP_SZ_4K          2'h1
`define MTAP_SZ_64K         2'h2
`define MTAP_MASK_1K        22'h3FFFFF
`define MTAP_MASK_4K        22'h3FFFFC
`define MTAP_MASK_64K       22'h3FFFC0
`define MTAP_MASK_1M        22'h3FFC00
`define MTAP_ZERO32         32'h00000000

`endif

// >>> mtap_lsu_model.sv
// Purpose: load/store side model issuing longword port accesses
// Assumes: one request in flight, answer one cycle later
// Notes:   idle address and data lines carry inverted junk
`timescale 1ns/1ns
module mtap_lsu_model (
  input  wire logic        mclk_in,
  input  wire logic        rsp_valid_in,
  input  wire logic        rsp_mapped_in,
  input  wire logic [31:0] rsp_rdata_in,
  input  wire logic        multi_hit_exc_in,
  output logic             req_valid_out,
  output logic             req_write_out,
  output logic      [31:0] req_addr_out,
  output logic      [31:0] req_wdata_out
);
  initial begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_addr_out  = 32'h0;
    req_wdata_out = 32'h0;
  end
  // ****************************************
  // one access: drive, hold one edge, sample
  // ****************************************
  task automatic access(input logic wr, input logic [31:0] a, d,
                        output logic [34:0] rsp);
    @(posedge mclk_in);
    req_valid_out <= 1'b1;
    req_write_out <= wr;
    req_addr_out  <= {a[31:2], 2'h0};
    req_wdata_out <= d;
    @(posedge mclk_in);
    req_valid_out <= 1'b0;
    req_addr_out  <= ~a;
    req_wdata_out <= ~d;
    #1 rsp = {rsp_valid_in, rsp_mapped_in, multi_hit_exc_in, rsp_rdata_in};
  endtask
endmodule // mtap_lsu_model

// >>> mtap_monitor.sv
// Purpose: port checks for the mapped translation-buffer port
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto every mtap_port
`timescale 1ns/1ns
`include "mtap_consts.vh"
module mtap_monitor (
  input wire logic        mclk_in,
  input wire logic        srst_in,
  input wire logic        req_valid_in,
  input wire logic        req_write_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [31:0] req_wdata_in,
  input wire logic [7:0]  cur_address_space_tag_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_mapped_out,
  input wire logic [31:0] rsp_rdata_out,
  input wire logic        multi_hit_exc_out
);
  wire [7:0] c8 = req_addr_in[`MTAP_CODE8_RNG];
  wire [8:0] c9 = req_addr_in[`MTAP_CODE9_RNG];
  wire       rd = req_valid_in && !req_write_in;
  wire       aw = req_valid_in && req_write_in &&
                  c8 == `MTAP_UNIFIED_TRANSLATION_BUFFER_AA_CODE && req_addr_in[`MTAP_ASSOC_BIT];
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // ****************************************
  // answer timing and decode
  // ****************************************
  sequence s_assoc_wr; aw; endsequence
  sequence s_assoc_rsp;
    rsp_valid_out && rsp_mapped_out && rsp_rdata_out == 32'h0;
  endsequence
  a_rsp_latency: assert property (req_valid_in |=> rsp_valid_out)
    else $error("answer missing");
  a_rsp_idle: assert property (!req_valid_in |=> !rsp_valid_out)
    else $error("answer without request");
  a_instruction_translation_buffer_aa_map: assert property (req_valid_in &&
    c8 == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_AA_CODE |=> rsp_mapped_out) else $error("aa decode");
  a_instruction_translation_buffer_da1_map: assert property (req_valid_in &&
    c9 == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA1_CODE |=> rsp_mapped_out) else $error("da1 decode");
  a_instruction_translation_buffer_da2_map: assert property (req_valid_in &&
    c9 == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA2_CODE |=> rsp_mapped_out) else $error("da2 decode");
  a_unified_translation_buffer_aa_map: assert property (req_valid_in &&
    c8 == `MTAP_UNIFIED_TRANSLATION_BUFFER_AA_CODE |=> rsp_mapped_out) else $error("uaa decode");
  a_unified_translation_buffer_da1_map: assert property (rd &&
    c9 == `MTAP_UNIFIED_TRANSLATION_BUFFER_DA1_CODE |=> rsp_mapped_out) else $error("uda1 decode");
  a_da2_reserved: assert property (rd && c9 == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA2_CODE
    |=> rsp_rdata_out[31:4] == 28'h0) else $error("da2 reserved bits");
  a_assoc_rsp: assert property (s_assoc_wr |=> s_assoc_rsp)
    else $error("assoc write answer");
  a_exc_cause: assert property (multi_hit_exc_out |-> $past(aw))
    else $error("exception without assoc write");
  a_unmapped_zero: assert property (req_valid_in && c8[7:1] == 7'h7A
    |=> !rsp_mapped_out && rsp_rdata_out == 32'h0) else $error("unmapped");
endmodule // mtap_monitor

bind mtap_port mtap_monitor u_mon (.mclk_in, .srst_in, .req_valid_in,
  .req_write_in, .req_addr_in, .req_wdata_in, .cur_address_space_tag_in,
  .rsp_valid_out, .rsp_mapped_out, .rsp_rdata_out, .multi_hit_exc_out);

// >>> mtap_port.v
// Purpose: memory-mapped read/write port onto the translation buffers
// Assumes: one request per cycle at most, answer one cycle later
// Notes:   instruction buffer 4 entries, unified buffer 64 entries
//
// Summary of operation
// - Instruction address array: code in bits 31:24, entry in 9:8, vpn/valid/tag.
// - Instruction address array read returns, write stores, vpn, valid, tag.
// - Each access has 32-bit address; writes add a 32-bit data word.
// - Software writes zero to reserved bits; reads may return anything there.
// - Instruction data array 1: code in bits 31:23, entry in 9:8.
// - Its fields: page 28:10, valid 8, size 7 and 4, right 6, c 3, shared 1.
// - Instruction data array 1 read returns, write loads, those fields.
// - Instruction data array 2: code in bits 31:23, entry in 9:8.
// - Its fields: space attribute 2:0, timing control 3; read and write both.
// - Unified address array: code in bits 31:24, entry in bits 13:8.
// - Address bit 7 chooses associative or indexed write.
// - Unified address fields: vpn 31:10, dirty 9, valid 8, tag 7:0.
// - Unified address array read ignores the association bit.
// - Indexed write (bit 7 zero) stores vpn, dirty, valid, tag.
// - Associative write compares all entries with data vpn and current tag.
// - No unified match: unified buffer unchanged, no exception.
// - Single unified match: update only its dirty and valid flags.
// - Several unified matches: raise the multiple-hit exception.
// - Instruction buffer compared in parallel; matching entry gets valid.
// - Instruction update happens even without a unified match.
// - Single unified match plus instruction match: unified entry contents copied into instruction entry.
// - Unified data array 1: code in bits 31:23, entry in bits 13:8.
// - Its fields: as instruction side, right 6:5, dirty 2, wt 0.
// - Unified data array 1 read returns all eight fields.
`timescale 1ns/1ns
`include "mtap_consts.vh"

module mtap_port (
  input  wire        mclk_in,
  input  wire        srst_in,
  input  wire        req_valid_in,
  input  wire        req_write_in,
  input  wire [31:0] req_addr_in,
  input  wire [31:0] req_wdata_in,
  input  wire [7:0]  cur_address_space_tag_in,
  output reg         rsp_valid_out,
  output reg         rsp_mapped_out,
  output reg  [31:0] rsp_rdata_out,
  output reg         multi_hit_exc_out
);

  // ************************************************************
  // entry storage
  // ************************************************************
  reg [21:0] it_vpn   [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg        it_v     [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg [7:0]  it_address_space_tag  [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg [18:0] it_ppn   [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg [1:0]  it_sz    [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg        it_pr    [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg        it_c     [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg        it_sh    [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg [2:0]  it_sa    [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg        it_tc    [0:`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1];
  reg [21:0] ut_vpn   [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg        ut_d     [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg        ut_v     [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg [7:0]  ut_address_space_tag  [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg [18:0] ut_ppn   [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg [1:0]  ut_sz    [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg [1:0]  ut_pr    [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg        ut_c     [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg        ut_sh    [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];
  reg        ut_wt    [0:`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1];

  // ************************************************************
  // address decode
  // ************************************************************
  wire [1:0] it_idx;
  wire [5:0] ut_idx;
  wire       sel_it_aa;
  wire       sel_it_da1;
  wire       sel_it_da2;
  wire       sel_ut_aa;
  wire       sel_ut_da1;
  wire       assoc;
  wire       wr;
  wire       it_wr_aa;
  wire       it_wr_da1;
  wire       it_wr_da2;
  wire       ut_wr_idx;
  wire       ut_wr_assoc;

  assign it_idx     = req_addr_in[`MTAP_INSTRUCTION_TRANSLATION_BUFFER_IDX_RNG];
  assign ut_idx     = req_addr_in[`MTAP_UNIFIED_TRANSLATION_BUFFER_IDX_RNG];
  assign sel_it_aa  = req_addr_in[`MTAP_CODE8_RNG] == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_AA_CODE;
  assign sel_it_da1 = req_addr_in[`MTAP_CODE9_RNG] == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA1_CODE;
  assign sel_it_da2 = req_addr_in[`MTAP_CODE9_RNG] == `MTAP_INSTRUCTION_TRANSLATION_BUFFER_DA2_CODE;
  assign sel_ut_aa  = req_addr_in[`MTAP_CODE8_RNG] == `MTAP_UNIFIED_TRANSLATION_BUFFER_AA_CODE;
  assign sel_ut_da1 = req_addr_in[`MTAP_CODE9_RNG] == `MTAP_UNIFIED_TRANSLATION_BUFFER_DA1_CODE;
  assign assoc      = req_addr_in[`MTAP_ASSOC_BIT];
  assign wr         = req_valid_in & req_write_in;
  assign it_wr_aa   = wr & sel_it_aa;
  assign it_wr_da1  = wr & sel_it_da1;
  assign it_wr_da2  = wr & sel_it_da2;
  assign ut_wr_idx  = wr & sel_ut_aa & ~assoc;
  assign ut_wr_assoc = wr & sel_ut_aa & assoc;

  // ************************************************************
  // compare mask by page size
  // ************************************************************
  function [21:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `MTAP_SZ_1K:  size_mask = `MTAP_MASK_1K;
        `MTAP_SZ_4K:  size_mask = `MTAP_MASK_4K;
        `MTAP_SZ_64K: size_mask = `MTAP_MASK_64K;
        default:      size_mask = `MTAP_MASK_1M;
      endcase
    end
  endfunction

  // ************************************************************
  // associative compare, every entry of both buffers
  // ************************************************************
  wire [21:0]                   cmp_vpn;
  wire [`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] ut_match;
  wire [`MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] ut_match_dec;
  wire [`MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] it_match;

  assign cmp_vpn = req_wdata_in[`MTAP_VPN_RNG];

  genvar g;
  generate
    for (g = 0; g < `MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES; g = g + 1) begin : g_cmp
      // valid, page number under size mask, tag unless shared
      assign ut_match[g] = ut_v[g] &
        (((ut_vpn[g] ^ cmp_vpn) & size_mask(ut_sz[g])) == 22'h000000) &
        (ut_sh[g] | (ut_address_space_tag[g] == cur_address_space_tag_in));
      if (g < `MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES) begin : g_it
        assign it_match[g] = it_v[g] &
          (((it_vpn[g] ^ cmp_vpn) & size_mask(it_sz[g])) == 22'h000000) &
          (it_sh[g] | (it_address_space_tag[g] == cur_address_space_tag_in));
      end
    end
  endgenerate

  assign ut_match_dec = ut_match - 64'h1;

  wire ut_any;
  wire ut_multi;
  assign ut_any   = |ut_match;
  assign ut_multi = |(ut_match & ut_match_dec);

  reg [5:0] ut_hit_idx;
  integer   k;
  always @* begin
    ut_hit_idx = 6'h00;
    for (k = 0; k < `MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES; k = k + 1) begin
      if (ut_match[k]) begin
        ut_hit_idx = k[5:0];
      end
    end
  end

  wire ut_single;
  assign ut_single = ut_any & ~ut_multi;

  // ************************************************************
  // instruction buffer writes
  // ************************************************************
  integer i;
  always @(posedge mclk_in) begin
    if (srst_in) begin
      for (i = 0; i < `MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; i = i + 1) begin
        it_vpn[i]  <= 22'h000000;
        it_v[i]    <= 1'b0;
        it_address_space_tag[i] <= 8'h00;
        it_ppn[i]  <= 19'h00000;
        it_sz[i]   <= 2'h0;
        it_pr[i]   <= 1'b0;
        it_c[i]    <= 1'b0;
        it_sh[i]   <= 1'b0;
        it_sa[i]   <= 3'h0;
        it_tc[i]   <= 1'b0;
      end
    end else begin
      if (it_wr_aa) begin
        it_vpn[it_idx]  <= req_wdata_in[`MTAP_VPN_RNG];
        it_v[it_idx]    <= req_wdata_in[`MTAP_VALID_BIT];
        it_address_space_tag[it_idx] <= req_wdata_in[`MTAP_ADDRESS_SPACE_TAG_RNG];
      end
      if (it_wr_da1) begin
        it_ppn[it_idx] <= req_wdata_in[`MTAP_PPN_RNG];
        it_v[it_idx]   <= req_wdata_in[`MTAP_VALID_BIT];
        it_sz[it_idx]  <= {req_wdata_in[`MTAP_SZ_HI_BIT],
                           req_wdata_in[`MTAP_SZ_LO_BIT]};
        it_pr[it_idx]  <= req_wdata_in[`MTAP_PR_HI_BIT];
        it_c[it_idx]   <= req_wdata_in[`MTAP_CACHE_BIT];
        it_sh[it_idx]  <= req_wdata_in[`MTAP_SHARED_BIT];
      end
      if (it_wr_da2) begin
        it_sa[it_idx] <= req_wdata_in[`MTAP_SA_RNG];
        it_tc[it_idx] <= req_wdata_in[`MTAP_TC_BIT];
      end
      for (i = 0; i < `MTAP_INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; i = i + 1) begin
        if (ut_wr_assoc && it_match[i]) begin
          it_v[i] <= req_wdata_in[`MTAP_VALID_BIT];
          if (ut_single) begin
            it_vpn[i]  <= ut_vpn[ut_hit_idx];
            it_address_space_tag[i] <= ut_address_space_tag[ut_hit_idx];
            it_ppn[i]  <= ut_ppn[ut_hit_idx];
            it_sz[i]   <= ut_sz[ut_hit_idx];
            it_pr[i]   <= ut_pr[ut_hit_idx][1];
            it_c[i]    <= ut_c[ut_hit_idx];
            it_sh[i]   <= ut_sh[ut_hit_idx];
          end
        end
      end
    end
  end

  // ************************************************************
  // unified buffer writes
  // ************************************************************
  integer u;
  always @(posedge mclk_in) begin
    if (srst_in) begin
      for (u = 0; u < `MTAP_UNIFIED_TRANSLATION_BUFFER_ENTRIES; u = u + 1) begin
        ut_vpn[u]  <= 22'h000000;
        ut_d[u]    <= 1'b0;
        ut_v[u]    <= 1'b0;
        ut_address_space_tag[u] <= 8'h00;
        ut_ppn[u]  <= 19'h00000;
        ut_sz[u]   <= 2'h0;
        ut_pr[u]   <= 2'h0;
        ut_c[u]    <= 1'b0;
        ut_sh[u]   <= 1'b0;
        ut_wt[u]   <= 1'b0;
      end
    end else begin
      if (ut_wr_idx) begin
        ut_vpn[ut_idx]  <= req_wdata_in[`MTAP_VPN_RNG];
        ut_d[ut_idx]    <= req_wdata_in[`MTAP_DIRTY_AA_BIT];
        ut_v[ut_idx]    <= req_wdata_in[`MTAP_VALID_BIT];
        ut_address_space_tag[ut_idx] <= req_wdata_in[`MTAP_ADDRESS_SPACE_TAG_RNG];
      end
      // no match or several matches leave the buffer alone
      if (ut_wr_assoc && ut_single) begin
        ut_d[ut_hit_idx] <= req_wdata_in[`MTAP_DIRTY_AA_BIT];
        ut_v[ut_hit_idx] <= req_wdata_in[`MTAP_VALID_BIT];
      end
    end
  end

  // ************************************************************
  // read data assembly
  // ************************************************************
  reg [31:0] next_rdata;
  reg        next_mapped;
  always @* begin
    next_rdata  = `MTAP_ZERO32;
    next_mapped = 1'b1;
    if (sel_it_aa) begin
      next_rdata[`MTAP_VPN_RNG]   = it_vpn[it_idx];
      next_rdata[`MTAP_VALID_BIT] = it_v[it_idx];
      next_rdata[`MTAP_ADDRESS_SPACE_TAG_RNG]  = it_address_space_tag[it_idx];
    end else if (sel_it_da1) begin
      next_rdata[`MTAP_PPN_RNG]    = it_ppn[it_idx];
      next_rdata[`MTAP_VALID_BIT]  = it_v[it_idx];
      next_rdata[`MTAP_SZ_HI_BIT]  = it_sz[it_idx][1];
      next_rdata[`MTAP_SZ_LO_BIT]  = it_sz[it_idx][0];
      next_rdata[`MTAP_PR_HI_BIT]  = it_pr[it_idx];
      next_rdata[`MTAP_CACHE_BIT]  = it_c[it_idx];
      next_rdata[`MTAP_SHARED_BIT] = it_sh[it_idx];
    end else if (sel_it_da2) begin
      next_rdata[`MTAP_SA_RNG] = it_sa[it_idx];
      next_rdata[`MTAP_TC_BIT] = it_tc[it_idx];
    end else if (sel_ut_aa) begin
      next_rdata[`MTAP_VPN_RNG]      = ut_vpn[ut_idx];
      next_rdata[`MTAP_DIRTY_AA_BIT] = ut_d[ut_idx];
      next_rdata[`MTAP_VALID_BIT]    = ut_v[ut_idx];
      next_rdata[`MTAP_ADDRESS_SPACE_TAG_RNG]     = ut_address_space_tag[ut_idx];
    end else if (sel_ut_da1) begin
      next_rdata[`MTAP_PPN_RNG]      = ut_ppn[ut_idx];
      next_rdata[`MTAP_VALID_BIT]    = ut_v[ut_idx];
      next_rdata[`MTAP_SZ_HI_BIT]    = ut_sz[ut_idx][1];
      next_rdata[`MTAP_SZ_LO_BIT]    = ut_sz[ut_idx][0];
      next_rdata[`MTAP_PR_HI_BIT]    = ut_pr[ut_idx][1];
      next_rdata[`MTAP_PR_LO_BIT]    = ut_pr[ut_idx][0];
      next_rdata[`MTAP_CACHE_BIT]    = ut_c[ut_idx];
      next_rdata[`MTAP_DIRTY_DA_BIT] = ut_d[ut_idx];
      next_rdata[`MTAP_SHARED_BIT]   = ut_sh[ut_idx];
      next_rdata[`MTAP_WT_BIT]       = ut_wt[ut_idx];
    end else begin
      next_mapped = 1'b0;
    end
  end

  // ************************************************************
  // answer registers
  // ************************************************************
  always @(posedge mclk_in) begin
    if (srst_in) begin
      rsp_valid_out     <= 1'b0;
      rsp_mapped_out    <= 1'b0;
      rsp_rdata_out     <= `MTAP_ZERO32;
      multi_hit_exc_out <= 1'b0;
    end else begin
      rsp_valid_out     <= req_valid_in;
      rsp_mapped_out    <= req_valid_in & next_mapped;
      rsp_rdata_out     <= (req_valid_in & ~req_write_in) ?
                           next_rdata : `MTAP_ZERO32;
      multi_hit_exc_out <= ut_wr_assoc & ut_multi;
    end
  end

endmodule // mtap_port

// >>> tb.sv
// Purpose: self-checking bench for the mapped translation-buffer port
// Assumes: the lsu model issues every request
// Notes:   a second reset clears state before associative tests
`timescale 1ns/1ns
module tb;
  logic        mclk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [7:0]  cur_address_space_tag_in = 8'h5A;
  logic        req_valid_in, req_write_in, rsp_valid_out, rsp_mapped_out;
  logic        multi_hit_exc_out;
  logic [31:0] req_addr_in, req_wdata_in, rsp_rdata_out;
  logic [34:0] rsp;
  int          ux[4] = '{0, 1, 62, 63};
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #2 mclk_in = ~mclk_in;
  mtap_port u_dut (.mclk_in, .srst_in, .req_valid_in, .req_write_in,
    .req_addr_in, .req_wdata_in, .cur_address_space_tag_in, .rsp_valid_out,
    .rsp_mapped_out, .rsp_rdata_out, .multi_hit_exc_out);
  mtap_lsu_model u_lsu (.mclk_in, .rsp_valid_in(rsp_valid_out),
    .rsp_mapped_in(rsp_mapped_out), .rsp_rdata_in(rsp_rdata_out),
    .multi_hit_exc_in(multi_hit_exc_out), .req_valid_out(req_valid_in),
    .req_write_out(req_write_in), .req_addr_out(req_addr_in),
    .req_wdata_out(req_wdata_in));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [34:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge mclk_in);
    srst_in <= 1'b1;
    repeat (19) @(posedge mclk_in);
    srst_in <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d, input logic exc);
    u_lsu.access(1'b1, a, d, rsp);
    check($sformatf("write %h", a), rsp, {2'b11, exc, 32'h0});
  endtask
  task automatic rd(input logic [31:0] a, exp, input logic map = 1'b1);
    u_lsu.access(1'b0, a, 32'h0, rsp);
    check($sformatf("read %h", a), rsp, {1'b1, map, 1'b0, exp});
  endtask
  function automatic logic [31:0] ia(int i);
    return {22'h2AAAA ^ 22'(i), 2'b01, 8'h30 + 8'(i)};
  endfunction
  function automatic logic [31:0] ua(int i);
    return {22'h155555 ^ 22'(i), i[0], 1'b1, 8'h40 + 8'(i)};
  endfunction
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    do_reset();
    rd(32'hF2000300, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(32'hF2000000 | 32'(i) << 8, ia(i), 1'b0);
      wr(32'hF3000000 | 32'(i) << 8, 32'h1FFFFDDA ^ 32'(i) << 10, 1'b0);
      wr(32'hF3800000 | 32'(i) << 8, 32'(i + 8), 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      rd(32'hF2000000 | 32'(i) << 8, ia(i));
      rd(32'hF3000000 | 32'(i) << 8, 32'h1FFFFDDA ^ 32'(i) << 10);
      rd(32'hF3800000 | 32'(i) << 8, 32'(i + 8));
    end
    foreach (ux[k]) wr(32'hF6000000 | 32'(ux[k]) << 8, ua(ux[k]), 1'b0);
    foreach (ux[k]) begin
      rd(32'hF6000080 | 32'(ux[k]) << 8, ua(ux[k]));
      rd(32'hF7000000 | 32'(ux[k]) << 8, 32'h100 | 32'(ux[k] & 1) << 2);
    end
    rd(32'hF4000000, 32'h0, 1'b0);
    rd(32'hF7800100, 32'h0, 1'b0);
    do_reset();
    wr(32'hF6000200, {22'h00A5A, 2'b01, 8'h5A}, 1'b0);
    wr(32'hF6000080, {22'h00A5A, 2'b11, 8'h00}, 1'b0);
    rd(32'hF6000200, {22'h00A5A, 2'b11, 8'h5A});
    wr(32'hF6000080, {22'h00B00, 2'b00, 8'h00}, 1'b0);
    @(posedge mclk_in) cur_address_space_tag_in <= 8'h5B;
    wr(32'hF6000080, {22'h00A5A, 2'b00, 8'h00}, 1'b0);
    @(posedge mclk_in) cur_address_space_tag_in <= 8'h5A;
    rd(32'hF6000200, {22'h00A5A, 2'b11, 8'h5A});
    wr(32'hF6000300, {22'h00A5A, 2'b01, 8'h5A}, 1'b0);
    wr(32'hF6000080, {22'h00A5A, 2'b00, 8'h00}, 1'b1);
    rd(32'hF6000200, {22'h00A5A, 2'b11, 8'h5A});
    wr(32'hF6000300, {22'h00C00, 2'b01, 8'h5A}, 1'b0);
    wr(32'hF2000100, {22'h00D00, 2'b01, 8'h5A}, 1'b0);
    wr(32'hF6000080, {22'h00D00, 2'b00, 8'h00}, 1'b0);
    rd(32'hF2000100, {22'h00D00, 2'b00, 8'h5A});
    wr(32'hF2000200, {22'h00A5A, 2'b01, 8'h5A}, 1'b0);
    wr(32'hF3000200, 32'h0ABCD100, 1'b0);
    wr(32'hF6000080, {22'h00A5A, 2'b11, 8'h00}, 1'b0);
    rd(32'hF3000200, 32'h00000100);
    rd(32'hF2000200, {22'h00A5A, 2'b01, 8'h5A});
    complete_run();
  end
endmodule // tb
